// ---- common/dso_defs.svh ----
// constants for the dual serial output and control block
`ifndef DSO_DEFS_SVH
`define DSO_DEFS_SVH
`define DSO_SAMPLE_W 12
`define DSO_TEST_PATTERN 12'hA63
`define DSO_RANGE_TOP 12'hFFF
`define DSO_RANGE_BOT 12'h000
`define DSO_LAST_BIT 4'hB
`define DSO_HALF_LAST_BIT 4'h5
`define DSO_BIT_DIV 4'h2
`define DSO_DLL_LOCK_CYC 16'h0400
`define DSO_SPI_HDR_LAST 5'h07
`define DSO_SPI_LAST 5'h0F
`define DSO_SPI_DONE 5'h10
`define DSO_SPI_ADDR_CFG 7'h00
`define DSO_SPI_ADDR_STAT 7'h01
`define DSO_CFG_RST 4'h2
`define DSO_CFG_W 4
`endif

// ---- common/dso_pkg.sv ----
// types shared by the dual serial output and control block
`default_nettype none
package dso_pkg;
  typedef struct packed {
    logic test_mode;
    logic align_same;
    logic single_lane;
    logic pwr_down;
  } dso_cfg_s;
  typedef enum logic [1:0] {
    DLL_HELD,
    DLL_ACQUIRE,
    DLL_LOCKED,
    DLL_LOST
  } dso_dll_e;
endpackage
`default_nettype wire

// ---- src/dso_sync2.sv ----
// two flip-flop synchroniser for levels
`timescale 1ns/1ps
`default_nettype none
module dso_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  always_ff @(posedge i_clk) begin
    meta_q <= i_d;
    sync_q <= meta_q;
  end
  assign o_q = sync_q;
endmodule // dso_sync2
`default_nettype wire

// ---- src/dso_lane_ser.sv ----
// per-channel sample holding and lane serialiser
`timescale 1ns/1ps
`default_nettype none
`include "dso_defs.svh"
module dso_lane_ser #(
  parameter int SAMPLE_W = `DSO_SAMPLE_W
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [SAMPLE_W-1:0] i_sample,
  input wire logic i_valid,
  input wire logic i_dual,
  input wire logic i_align_same,
  input wire logic i_test,
  input wire logic i_bit_stb,
  input wire logic i_word_start,
  input wire logic i_half_start,
  output logic o_pri,
  output logic o_sec,
  output logic o_range
);
  logic [SAMPLE_W-1:0] hold_q [2];
  logic par_q;
  logic [SAMPLE_W-1:0] pri_q;
  logic [SAMPLE_W-1:0] sec_q;
  logic range_q;
  logic sec_load;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      hold_q[0] <= '0;
      hold_q[1] <= '0;
      par_q <= 1'b0;
    end else if (i_valid) begin
      hold_q[par_q] <= i_sample;
      par_q <= i_dual ? ~par_q : 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      range_q <= 1'b0;
    end else if (i_valid) begin
      range_q <= (i_sample == `DSO_RANGE_TOP) ||
        (i_sample == `DSO_RANGE_BOT);
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pri_q <= '0;
    end else if (i_word_start) begin
      pri_q <= i_test ? `DSO_TEST_PATTERN : hold_q[0];
    end else if (i_bit_stb) begin
      pri_q <= {pri_q[SAMPLE_W-2:0], 1'b0};
    end
  end
  assign sec_load = i_dual &&
    (i_align_same ? i_word_start : i_half_start);
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sec_q <= '0;
    end else if (sec_load) begin
      sec_q <= i_test ? `DSO_TEST_PATTERN : hold_q[1];
    end else if (i_bit_stb && i_dual) begin
      sec_q <= {sec_q[SAMPLE_W-2:0], 1'b0};
    end
  end
  assign o_pri = pri_q[SAMPLE_W-1];
  assign o_sec = sec_q[SAMPLE_W-1];
  assign o_range = range_q;
endmodule // dso_lane_ser
`default_nettype wire

// ---- src/dso_ctrl.sv ----
// dual channel serial output lanes, control selection and status
`timescale 1ns/1ps
`default_nettype none
`include "dso_defs.svh"
module dso_ctrl #(
  parameter int SAMPLE_W = `DSO_SAMPLE_W,
  parameter logic [3:0] BIT_DIV = `DSO_BIT_DIV,
  parameter logic [15:0] DLL_LOCK_CYC = `DSO_DLL_LOCK_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [SAMPLE_W-1:0] i_samp_a,
  input wire logic [SAMPLE_W-1:0] i_samp_b,
  input wire logic i_samp_valid,
  input wire logic i_spi_enable,
  input wire logic i_pin_pwr_down,
  input wire logic i_lane_count_select,
  input wire logic i_word_alignment_select,
  input wire logic i_pin_test_mode,
  input wire logic i_dll_rst,
  input wire logic i_clk_jump,
  input wire logic i_sclk,
  input wire logic i_serial_chip_select_n,
  input wire logic i_serial_port_in,
  output logic o_serial_port_out,
  output logic o_serial_port_out_oe,
  output logic o_forwarded_bit_clock,
  output logic o_frame,
  output logic o_chan_a_primary_lane,
  output logic o_chan_a_primary_lane_oe,
  output logic o_chan_b_primary_lane,
  output logic o_chan_b_primary_lane_oe,
  output logic o_chan_a_secondary_lane,
  output logic o_chan_a_secondary_lane_oe,
  output logic o_chan_b_secondary_lane,
  output logic o_chan_b_secondary_lane_oe,
  output logic o_chan_a_range_flag,
  output logic o_chan_b_range_flag,
  output logic o_dll_lock
);

  // serial clock domain signals
  logic sclk_rst;
  logic [1:0] sclk_sync;
  logic spi_en_sclk;
  logic lock_sclk;
  logic [4:0] spi_cnt_q;
  logic [14:0] spi_shift_q;
  logic [7:0] spi_hdr_q;
  logic [`DSO_CFG_W-1:0] reg_cfg_q;
  logic [7:0] rd_word;
  logic sdo_q;

  // system clock domain signals
  logic [10:0] sys_sync;
  logic [`DSO_CFG_W-1:0] reg_cfg_sys;
  logic spi_en_sys;
  logic pin_pd_sys;
  logic pin_lcs_sys;
  logic pin_was_sys;
  logic pin_test_sys;
  logic dll_rst_sys;
  logic clk_jump_sys;
  logic [`DSO_CFG_W-1:0] cfg_prev_q;
  logic [`DSO_CFG_W-1:0] cfg_hold_q;
  dso_pkg::dso_cfg_s cfg_d;
  dso_pkg::dso_cfg_s cfg_q;
  logic [3:0] div_q;
  logic [3:0] bit_idx_q;
  logic bit_stb;
  logic word_start;
  logic half_start;
  logic fwd_clk_q;
  logic frame_q;
  dso_pkg::dso_dll_e dll_q;
  dso_pkg::dso_dll_e dll_d;
  logic [15:0] dll_cnt_q;
  logic lock_q;
  logic [1:0][SAMPLE_W-1:0] samp;
  logic [1:0] lane_pri;
  logic [1:0] lane_sec;
  logic [1:0] range_flag;

  // ---------------- serial register port ----------------

  dso_sync2 #(
    .WIDTH(1)
  ) u_sync_rst_sclk (
    .i_clk(i_sclk),
    .i_d(i_sys_rst),
    .o_q(sclk_rst)
  );

  dso_sync2 #(
    .WIDTH(2)
  ) u_sync_sclk (
    .i_clk(i_sclk),
    .i_d({i_spi_enable, lock_q}),
    .o_q(sclk_sync)
  );

  assign spi_en_sclk = sclk_sync[1];
  assign lock_sclk = sclk_sync[0];

  always_ff @(posedge i_sclk or posedge i_serial_chip_select_n) begin
    if (i_serial_chip_select_n) begin
      spi_cnt_q <= '0;
    end else if (spi_cnt_q != `DSO_SPI_DONE) begin
      spi_cnt_q <= spi_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge i_sclk) begin
    if (sclk_rst) begin
      spi_shift_q <= '0;
    end else if (spi_cnt_q != `DSO_SPI_DONE) begin
      spi_shift_q <= {spi_shift_q[13:0], i_serial_port_in};
    end
  end

  // header holds read flag and address
  always_ff @(posedge i_sclk) begin
    if (sclk_rst) begin
      spi_hdr_q <= '0;
    end else if (spi_cnt_q == `DSO_SPI_HDR_LAST) begin
      spi_hdr_q <= {spi_shift_q[6:0], i_serial_port_in};
    end
  end

  always_ff @(posedge i_sclk) begin
    if (sclk_rst) begin
      reg_cfg_q <= `DSO_CFG_RST;
    end else if (spi_en_sclk && (spi_cnt_q == `DSO_SPI_LAST) &&
        !spi_hdr_q[7] && (spi_hdr_q[6:0] == `DSO_SPI_ADDR_CFG)) begin
      reg_cfg_q <= {spi_shift_q[2:0], i_serial_port_in};
    end
  end

  // read data by address
  always_comb begin
    rd_word = '0;
    if (spi_hdr_q[6:0] == `DSO_SPI_ADDR_CFG) begin
      rd_word[`DSO_CFG_W-1:0] = reg_cfg_q;
    end else if (spi_hdr_q[6:0] == `DSO_SPI_ADDR_STAT) begin
      rd_word[0] = lock_sclk;
    end
  end

  always_ff @(negedge i_sclk or posedge i_serial_chip_select_n) begin
    if (i_serial_chip_select_n) begin
      sdo_q <= 1'b0;
    end else if (spi_hdr_q[7] && (spi_cnt_q > `DSO_SPI_HDR_LAST) &&
        (spi_cnt_q <= `DSO_SPI_LAST)) begin
      sdo_q <= rd_word[3'h7 - spi_cnt_q[2:0]];
    end
  end

  assign o_serial_port_out = sdo_q;
  assign o_serial_port_out_oe = !i_serial_chip_select_n && spi_en_sclk;

  // ---------------- configuration selection ----------------

  dso_sync2 #(
    .WIDTH(11)
  ) u_sync_sys (
    .i_clk(i_clk_sys),
    .i_d({reg_cfg_q, i_spi_enable, i_pin_pwr_down, i_lane_count_select,
      i_word_alignment_select, i_pin_test_mode, i_dll_rst, i_clk_jump}),
    .o_q(sys_sync)
  );

  assign reg_cfg_sys = sys_sync[10:7];
  assign spi_en_sys = sys_sync[6];
  assign pin_pd_sys = sys_sync[5];
  assign pin_lcs_sys = sys_sync[4];
  assign pin_was_sys = sys_sync[3];
  assign pin_test_sys = sys_sync[2];
  assign dll_rst_sys = sys_sync[1];
  assign clk_jump_sys = sys_sync[0];

  // config word taken only once two samples agree
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cfg_prev_q <= `DSO_CFG_RST;
      cfg_hold_q <= `DSO_CFG_RST;
    end else begin
      cfg_prev_q <= reg_cfg_sys;
      if (cfg_prev_q == reg_cfg_sys) begin
        cfg_hold_q <= reg_cfg_sys;
      end
    end
  end

  always_comb begin
    if (spi_en_sys) begin
      cfg_d = dso_pkg::dso_cfg_s'(cfg_hold_q);
    end else begin
      cfg_d.pwr_down = pin_pd_sys;
      cfg_d.single_lane = pin_lcs_sys;
      cfg_d.align_same = pin_was_sys;
      cfg_d.test_mode = pin_test_sys;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cfg_q <= dso_pkg::dso_cfg_s'(`DSO_CFG_RST);
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ---------------- bit timing and framing ----------------

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      div_q <= '0;
    end else if (div_q == BIT_DIV - 4'h1) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign bit_stb = (div_q == BIT_DIV - 4'h1) && !cfg_q.pwr_down;
  assign word_start = bit_stb && (bit_idx_q == `DSO_LAST_BIT);
  assign half_start = bit_stb && (bit_idx_q == `DSO_HALF_LAST_BIT);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      bit_idx_q <= `DSO_LAST_BIT;
    end else if (word_start) begin
      bit_idx_q <= '0;
    end else if (bit_stb) begin
      bit_idx_q <= bit_idx_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || cfg_q.pwr_down) begin
      fwd_clk_q <= 1'b0;
    end else if (bit_stb) begin
      fwd_clk_q <= ~fwd_clk_q;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || cfg_q.pwr_down) begin
      frame_q <= 1'b0;
    end else if (word_start) begin
      frame_q <= 1'b1;
    end else if (half_start) begin
      frame_q <= 1'b0;
    end
  end

  assign o_forwarded_bit_clock = fwd_clk_q;
  assign o_frame = frame_q;

  // ---------------- channel serialisers ----------------

  assign samp[0] = i_samp_a;
  assign samp[1] = i_samp_b;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    dso_lane_ser #(
      .SAMPLE_W(SAMPLE_W)
    ) u_ser (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_sample(samp[ch]),
      .i_valid(i_samp_valid),
      .i_dual(!cfg_q.single_lane),
      .i_align_same(cfg_q.align_same),
      .i_test(cfg_q.test_mode),
      .i_bit_stb(bit_stb),
      .i_word_start(word_start),
      .i_half_start(half_start),
      .o_pri(lane_pri[ch]),
      .o_sec(lane_sec[ch]),
      .o_range(range_flag[ch])
    );
  end

  assign o_chan_a_primary_lane = lane_pri[0];
  assign o_chan_b_primary_lane = lane_pri[1];
  assign o_chan_a_secondary_lane = lane_sec[0];
  assign o_chan_b_secondary_lane = lane_sec[1];
  assign o_chan_a_primary_lane_oe = 1'b1;
  assign o_chan_b_primary_lane_oe = 1'b1;
  assign o_chan_a_secondary_lane_oe = !cfg_q.single_lane;
  assign o_chan_b_secondary_lane_oe = !cfg_q.single_lane;
  assign o_chan_a_range_flag = range_flag[0];
  assign o_chan_b_range_flag = range_flag[1];

  // ---------------- delay loop lock status ----------------

  always_comb begin
    dll_d = dll_q;
    case (dll_q)
      dso_pkg::DLL_HELD: begin
        if (!dll_rst_sys) begin
          dll_d = dso_pkg::DLL_ACQUIRE;
        end
      end
      dso_pkg::DLL_ACQUIRE: begin
        if (dll_rst_sys) begin
          dll_d = dso_pkg::DLL_HELD;
        end else if (clk_jump_sys) begin
          dll_d = dso_pkg::DLL_LOST;
        end else if (dll_cnt_q == DLL_LOCK_CYC - 16'h0001) begin
          dll_d = dso_pkg::DLL_LOCKED;
        end
      end
      dso_pkg::DLL_LOCKED: begin
        if (dll_rst_sys) begin
          dll_d = dso_pkg::DLL_HELD;
        end else if (clk_jump_sys) begin
          dll_d = dso_pkg::DLL_LOST;
        end
      end
      dso_pkg::DLL_LOST: begin
        if (dll_rst_sys) begin
          dll_d = dso_pkg::DLL_HELD;
        end
      end
      default: begin
        dll_d = dso_pkg::DLL_HELD;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      dll_q <= dso_pkg::DLL_ACQUIRE;
    end else begin
      dll_q <= dll_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || (dll_q != dso_pkg::DLL_ACQUIRE) || clk_jump_sys) begin
      dll_cnt_q <= '0;
    end else begin
      dll_cnt_q <= dll_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= (dll_d == dso_pkg::DLL_LOCKED);
    end
  end

  assign o_dll_lock = lock_q;

endmodule // dso_ctrl
`default_nettype wire

// ---- sim/dso_ctrl_sva.sv ----
// assertion checker for the dual serial output block
`timescale 1ns/1ps
`default_nettype none
module dso_ctrl_sva #(
  parameter logic [3:0] BIT_DIV = 4'h2
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [11:0] i_samp_a,
  input wire logic i_samp_valid,
  input wire logic i_spi_enable,
  input wire logic i_pin_pwr_down,
  input wire logic i_lane_count_select,
  input wire logic i_clk_jump,
  input wire logic i_serial_chip_select_n,
  input wire logic o_serial_port_out_oe,
  input wire logic o_forwarded_bit_clock,
  input wire logic o_frame,
  input wire logic o_chan_a_primary_lane,
  input wire logic o_chan_a_primary_lane_oe,
  input wire logic o_chan_a_secondary_lane_oe,
  input wire logic o_chan_a_range_flag,
  input wire logic o_dll_lock
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  logic [7:0] hi_q;
  // counts cycles of frame high
  always_ff @(posedge i_clk_sys) begin
    hi_q <= o_frame ? hi_q + 8'h01 : 8'h00;
  end
  property p_pri_oe; o_chan_a_primary_lane_oe; endproperty
  a_pri_oe: assert property (p_pri_oe)
    else $error("primary lane enable low");
  property p_sdo_off; i_serial_chip_select_n |-> !o_serial_port_out_oe;
  endproperty
  a_sdo_off: assert property (p_sdo_off)
    else $error("serial out driven while deselected");
  property p_lane_step;
    $stable(o_forwarded_bit_clock) |-> $stable(o_chan_a_primary_lane);
  endproperty
  a_lane_step: assert property (p_lane_step)
    else $error("lane moved without a clock edge");
  property p_frame_len;
    disable iff (i_sys_rst || i_pin_pwr_down)
    $fell(o_frame) |-> hi_q == 8'(6 * BIT_DIV);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame high span wrong");
  property p_range;
    i_samp_valid |=> o_chan_a_range_flag ==
      ($past(i_samp_a) == 12'hFFF || $past(i_samp_a) == 12'h000);
  endproperty
  a_range: assert property (p_range)
    else $error("range flag wrong after sample");
  property p_range_hold; !i_samp_valid |=> $stable(o_chan_a_range_flag);
  endproperty
  a_range_hold: assert property (p_range_hold)
    else $error("range flag moved without sample");
  property p_single;
    (!i_spi_enable && i_lane_count_select) [*8] |->
      !o_chan_a_secondary_lane_oe;
  endproperty
  a_single: assert property (p_single)
    else $error("secondary lane driven in single lane");
  property p_dual;
    (!i_spi_enable && !i_lane_count_select) [*8] |->
      o_chan_a_secondary_lane_oe;
  endproperty
  a_dual: assert property (p_dual)
    else $error("secondary lane off in dual lane");
  property p_lock_drop; $rose(i_clk_jump) |-> ##[1:6] !o_dll_lock;
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("lock stayed high after clock jump");
  c_frame: cover property ($fell(o_frame));
  c_lock: cover property ($rose(o_dll_lock));
  c_range: cover property ($rose(o_chan_a_range_flag));
endmodule // dso_ctrl_sva
bind dso_ctrl dso_ctrl_sva #(.BIT_DIV(BIT_DIV)) i_dso_ctrl_sva (.*);
`default_nettype wire

// ---- sim/dso_rx_model.sv ----
// capture model of the receiving logic at the serial lanes
`timescale 1ns/1ps
`default_nettype none
module dso_rx_model (
  input wire logic i_clk_sys,
  input wire logic i_fwd,
  input wire logic i_frame,
  input wire logic i_pa,
  input wire logic i_pb,
  input wire logic i_sa,
  input wire logic i_sb,
  output logic [11:0] o_word_pa,
  output logic [11:0] o_word_pb,
  output logic [11:0] o_word_sa,
  output logic [11:0] o_word_sb,
  output logic [11:0] o_word_sr,
  output logic [7:0] o_frames
);
  logic fwd_q, frm_q;
  logic [11:0] pa_q, pb_q, sa_q, sb_q;
  initial o_frames = 8'h00;
  always @(posedge i_clk_sys) begin
    fwd_q <= i_fwd;
    frm_q <= i_frame;
    if (i_fwd != fwd_q) begin
      pa_q <= {pa_q[10:0], i_pa};
      pb_q <= {pb_q[10:0], i_pb};
      sa_q <= {sa_q[10:0], i_sa};
      sb_q <= {sb_q[10:0], i_sb};
      if (i_frame && !frm_q) begin
        o_word_pa <= pa_q;
        o_word_pb <= pb_q;
        o_word_sr <= sa_q;
        o_frames <= o_frames + 8'h01;
      end
      if (!i_frame && frm_q) begin
        o_word_sa <= sa_q;
        o_word_sb <= sb_q;
      end
    end
  end
endmodule // dso_rx_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking testbench for the dual serial output block
`timescale 1ns/1ps
`default_nettype none
`include "dso_defs.svh"
module tb_top;
  logic i_clk_sys, i_sys_rst, i_samp_valid, i_spi_enable, i_pin_pwr_down;
  logic i_lane_count_select, i_word_alignment_select, i_pin_test_mode;
  logic i_dll_rst, i_clk_jump, i_sclk, i_serial_chip_select_n;
  logic i_serial_port_in, o_serial_port_out, o_serial_port_out_oe;
  logic o_forwarded_bit_clock, o_frame, o_dll_lock;
  logic o_chan_a_primary_lane, o_chan_a_primary_lane_oe;
  logic o_chan_b_primary_lane, o_chan_b_primary_lane_oe;
  logic o_chan_a_secondary_lane, o_chan_a_secondary_lane_oe;
  logic o_chan_b_secondary_lane, o_chan_b_secondary_lane_oe;
  logic o_chan_a_range_flag, o_chan_b_range_flag;
  logic [11:0] i_samp_a, i_samp_b, w_pa, w_pb, w_sa, w_sb, w_sr;
  logic [7:0] n_frm, rd;
  logic rd_oe;
  int errors, compares;
  dso_ctrl #(.DLL_LOCK_CYC(16'h0010)) i_dso_ctrl (.*);
  dso_rx_model i_dso_rx_model (.i_clk_sys(i_clk_sys),
    .i_fwd(o_forwarded_bit_clock), .i_frame(o_frame),
    .i_pa(o_chan_a_primary_lane), .i_pb(o_chan_b_primary_lane),
    .i_sa(o_chan_a_secondary_lane), .i_sb(o_chan_b_secondary_lane),
    .o_word_pa(w_pa), .o_word_pb(w_pb), .o_word_sa(w_sa),
    .o_word_sb(w_sb), .o_word_sr(w_sr), .o_frames(n_frm));
  always #2.5 i_clk_sys = ~i_clk_sys;
  task automatic chk(input string n, input logic [11:0] got, exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic frames(input int n);
    int k;
    logic [7:0] f;
    repeat (n) begin
      f = n_frm;
      k = 0;
      while (n_frm == f && k < 200) begin
        @(posedge i_clk_sys);
        k++;
      end
      if (k == 200) errors++;
    end
  endtask
  task automatic strobe(input logic [11:0] a, b);
    i_samp_a <= a;
    i_samp_b <= b;
    i_samp_valid <= 1'b1;
    @(posedge i_clk_sys);
    i_samp_valid <= 1'b0;
  endtask
  task automatic spi(input logic [15:0] w);
    #1.3;
    i_serial_chip_select_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      i_serial_port_in <= w[i];
      #80 i_sclk <= 1'b1;
      if (i < 8) rd[i] = o_serial_port_out;
      if (i == 0) rd_oe = o_serial_port_out_oe;
      #80 i_sclk <= 1'b0;
    end
    #80 i_serial_chip_select_n <= 1'b1;
    i_serial_port_in <= ~w[0];
  endtask
  task automatic t_reset;
    repeat (6) begin
      @(posedge i_clk_sys);
      i_sclk <= ~i_sclk;
    end
    chk("frame", o_frame, 0);
    chk("sec_oe", o_chan_a_secondary_lane_oe, 0);
    i_sys_rst <= 1'b0;
    #1.3;
    repeat (4) begin
      #80 i_sclk <= 1'b1;
      #80 i_sclk <= 1'b0;
    end
    @(posedge i_clk_sys);
  endtask
  task automatic t_single;
    logic [11:0] e;
    for (int i = 0; i < 3; i++) begin
      e = 12'h5C3 ^ 12'(i * 273);
      strobe(e, ~e);
      frames(3);
      chk("pri_a", w_pa, e);
      chk("pri_b", w_pb, ~e);
    end
    i_pin_test_mode <= 1'b1;
    frames(4);
    chk("test_a", w_pa, `DSO_TEST_PATTERN);
    i_pin_test_mode <= 1'b0;
    frames(3);
  endtask
  task automatic t_dual;
    i_lane_count_select <= 1'b0;
    frames(2);
    strobe(12'h111, 12'h222);
    @(posedge i_clk_sys);
    strobe(12'h333, 12'h444);
    frames(4);
    chk("sec_oe", o_chan_a_secondary_lane_oe, 1);
    chk("sec_oe_b", o_chan_b_secondary_lane_oe, 1);
    chk("pair_p", w_pa, 12'h111);
    chk("pair_s", w_sa, 12'h333);
    chk("pair_sb", w_sb, 12'h444);
    i_word_alignment_select <= 1'b1;
    frames(2);
    strobe(12'h555, 12'h666);
    @(posedge i_clk_sys);
    strobe(12'h777, 12'h888);
    frames(4);
    chk("align_p", w_pa, 12'h555);
    chk("align_s", w_sr, 12'h777);
    i_word_alignment_select <= 1'b0;
    i_lane_count_select <= 1'b1;
    frames(2);
  endtask
  task automatic t_range;
    logic [11:0] v [4] = '{12'hFFF, 12'h001, 12'h000, 12'hFFE};
    for (int i = 0; i < 4; i++) begin
      strobe(v[i], v[3-i]);
      cyc(3);
      chk("range_a", o_chan_a_range_flag, 12'(i % 2 == 0));
      chk("range_b", o_chan_b_range_flag, 12'(i % 2));
    end
  endtask
  task automatic t_pd;
    logic pa;
    i_pin_pwr_down <= 1'b1;
    cyc(8);
    pa = o_chan_a_primary_lane;
    cyc(40);
    chk("hold_a", o_chan_a_primary_lane, pa);
    chk("fwd_pd", o_forwarded_bit_clock, 0);
    chk("oe_a", o_chan_a_primary_lane_oe, 1);
    chk("oe_b", o_chan_b_primary_lane_oe, 1);
    chk("frame_pd", o_frame, 0);
    i_pin_pwr_down <= 1'b0;
    frames(3);
  endtask
  task automatic t_spi;
    i_spi_enable <= 1'b1;
    i_lane_count_select <= 1'b0;
    cyc(10);
    chk("pins_off", o_chan_a_secondary_lane_oe, 0);
    spi(16'h0000);
    cyc(10);
    chk("spi_dual", o_chan_a_secondary_lane_oe, 1);
    spi(16'h8000);
    chk("cfg_rd", rd, 8'h00);
    spi(16'h8100);
    chk("stat_rd", rd, 8'h01);
    spi(16'h8500);
    chk("unmapped", rd, 8'h00);
    chk("sdo_oe", rd_oe, 1);
    spi(16'h000C);
    frames(3);
    chk("reg_test", w_sr, `DSO_TEST_PATTERN);
    spi(16'h8000);
    chk("cfg_rd2", rd, 8'h0C);
    spi(16'h0002);
    cyc(10);
    chk("spi_single", o_chan_a_secondary_lane_oe, 0);
    i_spi_enable <= 1'b0;
    cyc(10);
    chk("pins_on", o_chan_a_secondary_lane_oe, 1);
    spi(16'h8100);
    chk("port_off", rd_oe, 0);
    i_lane_count_select <= 1'b1;
    cyc(10);
  endtask
  task automatic t_dll;
    chk("lock", o_dll_lock, 1);
    i_clk_jump <= 1'b1;
    cyc(8);
    i_clk_jump <= 1'b0;
    cyc(40);
    chk("lost", o_dll_lock, 0);
    i_dll_rst <= 1'b1;
    cyc(4);
    i_dll_rst <= 1'b0;
    cyc(40);
    chk("relock", o_dll_lock, 1);
  endtask
  initial begin
    {i_clk_sys, i_samp_valid, i_spi_enable, i_pin_pwr_down} = 4'h0;
    {i_word_alignment_select, i_pin_test_mode, i_dll_rst} = 3'h0;
    {i_clk_jump, i_sclk, i_serial_port_in} = 3'h0;
    {i_sys_rst, i_lane_count_select, i_serial_chip_select_n} = 3'h7;
    {i_samp_a, i_samp_b} = 24'h0;
    errors = 0;
    compares = 0;
    t_reset();
    t_single();
    t_dual();
    t_range();
    t_pd();
    t_spi();
    t_dll();
    wrap_up();
  end
  initial begin
    #100000;
    errors++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
